// *** rtl/dbg_core_end.sv ***
`timescale 1ns/10ps
module dbg_core_end (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  dbg_sideband_if.core LINK,
  input wire dbg_pkg::cpu_vec_t CORE_WARM_RST_IN,
  input wire dbg_pkg::cpu_vec_t CP_ACC_REQ_IN,
  output dbg_pkg::cpu_vec_t CP_ACC_GRANT_OUT,
  output dbg_pkg::cpu_vec_t CP_ACC_DENY_OUT,
  output dbg_pkg::cpu_vec_t SW_LOCK_OUT,
  output dbg_pkg::cpu_vec_t CORE_IN_RESET_OUT,
  output dbg_pkg::cpu_vec_t CORE_HALTED_OUT,
  output logic [dbg_pkg::NUM_CPU*dbg_pkg::ROM_W-1:0] ROM_BASE_OUT,
  output dbg_pkg::cpu_vec_t ROM_VALID_OUT,
  output logic [dbg_pkg::NUM_CPU*dbg_pkg::SELF_W-1:0] SELF_OFFSET_OUT,
  output dbg_pkg::cpu_vec_t SELF_VALID_OUT
);
  import dbg_pkg::*;

  cpu_vec_t ack;
  cpu_vec_t taken;
  cpu_vec_t restarted;
  cpu_vec_t in_reset;
  cpu_vec_t halted;

  // ---------------------------------------------------------------
  // one sequencer per processor, bit n serves processor n
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CPU; gi++) begin : g_cpu
      dbg_cpu_slice u_slice (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .warm_rst_in(CORE_WARM_RST_IN[gi]),
        .hold_in(LINK.hold_warm_reset[gi]), // [R4] [R13]
        .ext_req_in(LINK.ext_debug_request[gi]),
        .halt_req_in(LINK.halt_request[gi]),
        .restart_req_in(LINK.restart_request[gi]),
        .ack_out(ack[gi]),
        .taken_out(taken[gi]),
        .restarted_out(restarted[gi]),
        .in_reset_out(in_reset[gi]),
        .halted_out(halted[gi])
      );

      // -------------------------------------------------------------
      // address snapshots, taken only while this processor is in reset
      // -------------------------------------------------------------
      always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
          ROM_BASE_OUT[gi*ROM_W +: ROM_W] <= '0;
          ROM_VALID_OUT[gi] <= 1'b0;
        end else if (in_reset[gi]) begin
          ROM_BASE_OUT[gi*ROM_W +: ROM_W] <= LINK.rom_table_base; // [R7]
          ROM_VALID_OUT[gi] <= LINK.rom_table_base_valid; // [R15]
        end
      end

      always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
          SELF_OFFSET_OUT[gi*SELF_W +: SELF_W] <= '0;
          SELF_VALID_OUT[gi] <= 1'b0;
        end else if (in_reset[gi]) begin
          SELF_OFFSET_OUT[gi*SELF_W +: SELF_W] <= LINK.self_offset; // [R9]
          SELF_VALID_OUT[gi] <= LINK.self_offset_valid; // [R15]
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // link answers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      LINK.debug_acknowledge <= CPU_ZERO;
      LINK.restart_handshake <= CPU_ZERO;
      LINK.request_taken <= CPU_ZERO;
    end else begin
      LINK.debug_acknowledge <= ack; // [R12]
      LINK.restart_handshake <= restarted; // [R14]
      LINK.request_taken <= taken; // [R11]
    end
  end

  // ---------------------------------------------------------------
  // user-side status
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      CORE_IN_RESET_OUT <= {NUM_CPU{1'b1}};
      CORE_HALTED_OUT <= CPU_ZERO;
    end else begin
      CORE_IN_RESET_OUT <= in_reset;
      CORE_HALTED_OUT <= halted;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      SW_LOCK_OUT <= CPU_ZERO;
    end else begin
      SW_LOCK_OUT <= LINK.sw_lock_status; // [R6]
    end
  end

  // coprocessor debug access: granted or refused per cycle of request
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      CP_ACC_GRANT_OUT <= CPU_ZERO;
      CP_ACC_DENY_OUT <= CPU_ZERO;
    end else begin
      CP_ACC_GRANT_OUT <= CP_ACC_REQ_IN & LINK.sw_access_enable; // [R5]
      CP_ACC_DENY_OUT <= CP_ACC_REQ_IN & ~LINK.sw_access_enable; // [R5]
    end
  end

endmodule

// *** rtl/dbg_cpu_slice.sv ***
`timescale 1ns/10ps
module dbg_cpu_slice (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic warm_rst_in,
  input wire logic hold_in,
  input wire logic ext_req_in,
  input wire logic halt_req_in,
  input wire logic restart_req_in,
  output logic ack_out,
  output logic taken_out,
  output logic restarted_out,
  output logic in_reset_out,
  output logic halted_out
);
  import dbg_pkg::*;

  cpu_state_t state_ff;
  cpu_state_t nxt_state;

  // ---------------------------------------------------------------
  // per-processor run/halt/restart sequence
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RESET: begin
        if (!warm_rst_in && !hold_in) begin // [R4]
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (warm_rst_in) begin
          nxt_state = ST_RESET;
        end else if (ext_req_in || halt_req_in) begin // [R1] [R3]
          nxt_state = ST_HALT;
        end
      end
      ST_HALT: begin
        if (warm_rst_in) begin
          nxt_state = ST_RESET;
        end else if (restart_req_in) begin // [R14]
          nxt_state = ST_RESTART;
        end
      end
      ST_RESTART: begin
        if (warm_rst_in) begin
          nxt_state = ST_RESET;
        end else if (!restart_req_in) begin // [R14]
          nxt_state = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff <= ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all registered
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_out <= 1'b0;
      halted_out <= 1'b0;
      in_reset_out <= 1'b1;
      restarted_out <= 1'b0;
    end else begin
      ack_out <= (nxt_state == ST_HALT); // [R12]
      halted_out <= (nxt_state == ST_HALT);
      in_reset_out <= (nxt_state == ST_RESET);
      restarted_out <= (nxt_state == ST_RESTART); // [R14]
    end
  end

  // one-cycle pulse when an external request moves the processor to halt
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      taken_out <= 1'b0;
    end else begin
      taken_out <= (state_ff == ST_RUN) && (nxt_state == ST_HALT) && ext_req_in; // [R11]
    end
  end

endmodule

// *** rtl/dbg_ctrl_end.sv ***
`timescale 1ns/10ps
module dbg_ctrl_end (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  dbg_sideband_if.ctrl LINK,
  input wire logic [dbg_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT
);
  import dbg_pkg::*;

  logic [31:0] cfg_ff;
  logic do_wr;
  logic [31:0] rd_mux;
  cpu_vec_t ext_set;
  cpu_vec_t rst_set;
  cpu_vec_t taken_ff;
  cpu_vec_t taken_clr;

  // ---------------------------------------------------------------
  // Avalon slave: one wait state on every access
  // ---------------------------------------------------------------
  assign do_wr = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      AVS_WAITREQUEST_OUT <= 1'b1;
    end else if (AVS_WAITREQUEST_OUT) begin
      AVS_WAITREQUEST_OUT <= !(AVS_READ_IN || AVS_WRITE_IN);
    end else begin
      AVS_WAITREQUEST_OUT <= 1'b1;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (AVS_ADDRESS_IN)
      OFS_HALT: rd_mux[NUM_CPU-1:0] = LINK.halt_request;
      OFS_EXTREQ: rd_mux[NUM_CPU-1:0] = LINK.ext_debug_request;
      OFS_RESTART: rd_mux[NUM_CPU-1:0] = LINK.restart_request;
      OFS_CONFIG: rd_mux = cfg_ff;
      OFS_ROMBASE: rd_mux[ROM_W-1:0] = LINK.rom_table_base;
      OFS_SELFOFS: rd_mux[SELF_W-1:0] = LINK.self_offset;
      OFS_STATUS: begin
        rd_mux[STS_ACK_LSB +: NUM_CPU] = LINK.debug_acknowledge;
        rd_mux[STS_RSTD_LSB +: NUM_CPU] = LINK.restart_handshake;
      end
      OFS_TAKEN: rd_mux[NUM_CPU-1:0] = taken_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data is loaded while waitrequest is high and stands at the answering edge
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      AVS_READDATA_OUT <= 32'h0000_0000;
    end else if (AVS_READ_IN && AVS_WAITREQUEST_OUT) begin
      AVS_READDATA_OUT <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // plain control registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      LINK.halt_request <= CPU_ZERO;
    end else if (do_wr && AVS_ADDRESS_IN == OFS_HALT) begin
      LINK.halt_request <= AVS_WRITEDATA_IN[NUM_CPU-1:0]; // [R3] [R13]
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cfg_ff <= CFG_RESET;
    end else if (do_wr && AVS_ADDRESS_IN == OFS_CONFIG) begin
      cfg_ff <= 32'h0000_0000;
      cfg_ff[CFG_LOCK_LSB +: NUM_CPU] <= AVS_WRITEDATA_IN[CFG_LOCK_LSB +: NUM_CPU];
      cfg_ff[CFG_HOLD_LSB +: NUM_CPU] <= AVS_WRITEDATA_IN[CFG_HOLD_LSB +: NUM_CPU];
      cfg_ff[CFG_SWEN_LSB +: NUM_CPU] <= AVS_WRITEDATA_IN[CFG_SWEN_LSB +: NUM_CPU];
      cfg_ff[CFG_ROMV_BIT] <= AVS_WRITEDATA_IN[CFG_ROMV_BIT];
      cfg_ff[CFG_SELFV_BIT] <= AVS_WRITEDATA_IN[CFG_SELFV_BIT];
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      LINK.sw_lock_status <= CPU_ZERO;
      LINK.hold_warm_reset <= CPU_ZERO;
      LINK.sw_access_enable <= CPU_ZERO;
      LINK.rom_table_base_valid <= 1'b0;
      LINK.self_offset_valid <= 1'b0;
    end else begin
      LINK.sw_lock_status <= cfg_ff[CFG_LOCK_LSB +: NUM_CPU]; // [R6]
      LINK.hold_warm_reset <= cfg_ff[CFG_HOLD_LSB +: NUM_CPU];
      LINK.sw_access_enable <= cfg_ff[CFG_SWEN_LSB +: NUM_CPU];
      LINK.rom_table_base_valid <= cfg_ff[CFG_ROMV_BIT]; // [R8]
      LINK.self_offset_valid <= cfg_ff[CFG_SELFV_BIT]; // [R10]
    end
  end

  // unknown addresses: software leaves base zero with valid low
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      LINK.rom_table_base <= '0;
      LINK.self_offset <= '0;
    end else if (do_wr && AVS_ADDRESS_IN == OFS_ROMBASE) begin
      LINK.rom_table_base <= AVS_WRITEDATA_IN[ROM_W-1:0]; // [R8]
    end else if (do_wr && AVS_ADDRESS_IN == OFS_SELFOFS) begin
      LINK.self_offset <= AVS_WRITEDATA_IN[SELF_W-1:0]; // [R10]
    end
  end

  // ---------------------------------------------------------------
  // handshaked requests: set by a write of 1, dropped by the answer
  // ---------------------------------------------------------------

  assign ext_set = (do_wr && AVS_ADDRESS_IN == OFS_EXTREQ) ? AVS_WRITEDATA_IN[NUM_CPU-1:0] : CPU_ZERO;
  assign rst_set = (do_wr && AVS_ADDRESS_IN == OFS_RESTART) ? AVS_WRITEDATA_IN[NUM_CPU-1:0] : CPU_ZERO;
  assign taken_clr = (do_wr && AVS_ADDRESS_IN == OFS_TAKEN) ? AVS_WRITEDATA_IN[NUM_CPU-1:0] : CPU_ZERO;

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      LINK.ext_debug_request <= CPU_ZERO;
    end else begin
      LINK.ext_debug_request <= ext_set | (LINK.ext_debug_request & ~LINK.debug_acknowledge); // [R2]
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      LINK.restart_request <= CPU_ZERO;
    end else begin
      LINK.restart_request <= rst_set | (LINK.restart_request & ~LINK.restart_handshake); // [R14]
    end
  end

  // sticky record of taken requests, write 1 to clear, a new event wins
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      taken_ff <= CPU_ZERO;
    end else begin
      taken_ff <= LINK.request_taken | (taken_ff & ~taken_clr);
    end
  end

endmodule

// *** rtl/dbg_pkg.sv ***
// Summary of operation
// R1: external debug request is a level, 1 requests
// R2: controller holds request until acknowledge rises
// R3: halt request per processor, 1 requests halt
// R4: hold input keeps processor in reset after reset
// R5: coprocessor debug access only while enable is 1
// R6: lock status 1 set, 0 clear, exposed
// R7: ROM base bits 39:12 sampled only in reset
// R8: ROM base valid low, base tied zero if unknown
// R9: self offset bits 39:15 signed, sampled in reset
// R10: offset unknown means offset zero, valid low
// R11: trigger output marks external request taken
// R12: acknowledge is 1 when request acknowledged
// R13: bit n of each vector is processor n
// R14: restart held until handshake, then both drop
// R15: valid low sampled reports address not valid
package dbg_pkg;

  localparam int NUM_CPU = 4;
  localparam int ROM_HI = 39;
  localparam int ROM_LO = 12;
  localparam int SELF_LO = 15;
  localparam int ROM_W = ROM_HI - ROM_LO + 1;
  localparam int SELF_W = ROM_HI - SELF_LO + 1;

  typedef logic [NUM_CPU-1:0] cpu_vec_t;
  typedef logic [ROM_W-1:0] rom_base_t;
  typedef logic [SELF_W-1:0] self_off_t;

  // ---------------------------------------------------------------
  // controller register map, byte offsets
  // ---------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_HALT = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_EXTREQ = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_RESTART = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_ROMBASE = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_SELFOFS = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_TAKEN = 5'h1c;

  // config register fields
  localparam int CFG_LOCK_LSB = 0;
  localparam int CFG_HOLD_LSB = 4;
  localparam int CFG_SWEN_LSB = 8;
  localparam int CFG_ROMV_BIT = 16;
  localparam int CFG_SELFV_BIT = 17;
  // status register fields
  localparam int STS_ACK_LSB = 0;
  localparam int STS_RSTD_LSB = 4;

  localparam cpu_vec_t CPU_ZERO = 4'h0;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_RUN = 2'b01,
    ST_HALT = 2'b10,
    ST_RESTART = 2'b11
  } cpu_state_t;

endpackage

// *** rtl/dbg_sideband_if.sv ***
`timescale 1ns/10ps
interface dbg_sideband_if;
  import dbg_pkg::*;

  cpu_vec_t halt_request;
  cpu_vec_t ext_debug_request;
  cpu_vec_t sw_lock_status;
  cpu_vec_t hold_warm_reset;
  cpu_vec_t sw_access_enable;
  cpu_vec_t restart_request;
  rom_base_t rom_table_base;
  logic rom_table_base_valid;
  self_off_t self_offset;
  logic self_offset_valid;
  cpu_vec_t debug_acknowledge;
  cpu_vec_t restart_handshake;
  cpu_vec_t request_taken;

  modport core (
    input halt_request, ext_debug_request, sw_lock_status, hold_warm_reset, sw_access_enable,
    input restart_request, rom_table_base, rom_table_base_valid, self_offset, self_offset_valid,
    output debug_acknowledge, restart_handshake, request_taken
  );

  modport ctrl (
    output halt_request, ext_debug_request, sw_lock_status, hold_warm_reset, sw_access_enable,
    output restart_request, rom_table_base, rom_table_base_valid, self_offset, self_offset_valid,
    input debug_acknowledge, restart_handshake, request_taken
  );

endinterface

// *** test/dbg_sideband_props.sv ***
`timescale 1ns/10ps
module dbg_sideband_props (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire dbg_pkg::cpu_vec_t halt_request,
  input wire dbg_pkg::cpu_vec_t ext_debug_request,
  input wire dbg_pkg::cpu_vec_t hold_warm_reset,
  input wire dbg_pkg::cpu_vec_t restart_request,
  input wire dbg_pkg::cpu_vec_t debug_acknowledge,
  input wire dbg_pkg::cpu_vec_t restart_handshake,
  input wire dbg_pkg::cpu_vec_t request_taken
);
  import dbg_pkg::*;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);

  // ---------------------------------------------------------------
  // handshake steps
  // ---------------------------------------------------------------
  sequence s_req0_new;
    $rose(ext_debug_request[0]) && !hold_warm_reset[0];
  endsequence
  sequence s_restart0_new;
    $rose(restart_request[0]) && debug_acknowledge[0];
  endsequence
  sequence s_hs0_up;
    ##2 restart_handshake[0];
  endsequence

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_req_held_ack: assert property (
    (($past(ext_debug_request) & ~$past(debug_acknowledge)) & ~ext_debug_request) == 4'h0)
    else $error("ext request dropped before acknowledge");
  a_ack_req_time: assert property (s_req0_new |-> ##2 debug_acknowledge[0])
    else $error("acknowledge late for ext request");
  a_halt_ack_time: assert property (
    $rose(halt_request[1]) && !hold_warm_reset[1] |-> ##2 debug_acknowledge[1])
    else $error("acknowledge late for halt request");
  a_taken_one_cycle: assert property (
    request_taken != 4'h0 |=> (request_taken & $past(request_taken)) == 4'h0)
    else $error("taken pulse longer than one cycle");
  a_taken_with_ack: assert property ((request_taken & ~debug_acknowledge) == 4'h0)
    else $error("taken without acknowledge");
  a_taken_has_cause: assert property (
    (request_taken & ~$past(ext_debug_request, 2)) == 4'h0)
    else $error("taken without ext request");
  a_handshake_rise: assert property (s_restart0_new |-> s_hs0_up)
    else $error("restart handshake late");
  a_handshake_fall: assert property ($fell(restart_request[0]) |-> ##2 !restart_handshake[0])
    else $error("restart handshake not dropped");
  a_restart_held: assert property (
    (($past(restart_request) & ~$past(restart_handshake)) & ~restart_request) == 4'h0)
    else $error("restart request dropped early");
endmodule

// *** test/debug_halt_restart_sideband_test.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 40) begin @(posedge clk); n++; end \
  if (n >= 40) begin error_cnt++; $display("CHECK FAILED %0t wait ran out", $time); close_out(); end end
module debug_halt_restart_sideband_test;
  import dbg_pkg::*;
  typedef struct {logic [ADDR_W-1:0] a; logic w; logic [31:0] d; logic [31:0] e;} row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic waitreq;
  cpu_vec_t warm = 4'h0;
  cpu_vec_t acc = 4'h0;
  cpu_vec_t grant, deny, lock, in_rst, halted, romv, selfv;
  logic [NUM_CPU*ROM_W-1:0] rom_snap;
  logic [NUM_CPU*SELF_W-1:0] self_snap;
  int error_cnt = 0;
  int tests_run = 0;
  int n;
  row_t rows[9] = '{'{OFS_CONFIG, 1'b0, 32'h0, CFG_RESET}, '{OFS_STATUS, 1'b0, 32'h0, 32'h0},
    '{OFS_TAKEN, 1'b0, 32'h0, 32'h0}, '{OFS_ROMBASE, 1'b1, 32'hfabc_1234, 32'h0abc_1234},
    '{OFS_SELFOFS, 1'b1, 32'hf1ff_0001, 32'h01ff_0001}, '{OFS_CONFIG, 1'b1, 32'hffff_fa4c, 32'h0003_0a4c},
    '{5'h02, 1'b1, 32'hffff_ffff, 32'h0}, '{OFS_STATUS, 1'b1, 32'hffff_ffff, 32'h0},
    '{OFS_HALT, 1'b1, 32'h0000_00f0, 32'h0}};

  always #4 clk = ~clk;

  dbg_sideband_if lk();
  dbg_ctrl_end u_dbg_ctrl_end (.CLK_IN(clk), .RSTN_IN(rst_n), .LINK(lk), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(waitreq));
  dbg_core_end u_dbg_core_end (.CLK_IN(clk), .RSTN_IN(rst_n), .LINK(lk), .CORE_WARM_RST_IN(warm),
    .CP_ACC_REQ_IN(acc), .CP_ACC_GRANT_OUT(grant), .CP_ACC_DENY_OUT(deny), .SW_LOCK_OUT(lock),
    .CORE_IN_RESET_OUT(in_rst), .CORE_HALTED_OUT(halted), .ROM_BASE_OUT(rom_snap),
    .ROM_VALID_OUT(romv), .SELF_OFFSET_OUT(self_snap), .SELF_VALID_OUT(selfv));
  dbg_sideband_props u_dbg_sideband_props (.CLK_IN(clk), .RSTN_IN(rst_n),
    .halt_request(lk.halt_request), .ext_debug_request(lk.ext_debug_request),
    .hold_warm_reset(lk.hold_warm_reset), .restart_request(lk.restart_request),
    .debug_acknowledge(lk.debug_acknowledge), .restart_handshake(lk.restart_handshake),
    .request_taken(lk.request_taken));

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one access, held until waitrequest is sampled low
  task automatic bus(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= ~w;
    wdata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 40);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    `WAITC(k < 40)
  endtask

  initial begin
    repeat (4) @(posedge clk);
    `CHK(in_rst, 4'hf)
    rst_n <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      if (rows[i].w) begin
        bus(rows[i].a, 1'b1, rows[i].d);
      end
      bus(rows[i].a, 1'b0, 32'h0);
      `CHK(q, rows[i].e)
    end
    $display("test registers done");
    `CHK(lk.sw_lock_status, 4'hc)
    `CHK(lock, 4'hc)
    acc <= 4'hf;
    repeat (2) @(posedge clk);
    `CHK(grant, 4'ha)
    `CHK(deny, 4'h5)
    acc <= 4'h0;
    $display("test access done");
    warm <= 4'h6;
    repeat (3) @(posedge clk);
    warm <= 4'h0;
    repeat (4) @(posedge clk);
    `CHK(in_rst, 4'h4)
    `CHK(rom_snap[ROM_W +: ROM_W], 28'habc1234)
    `CHK(self_snap[SELF_W +: SELF_W], 25'h1ff0001)
    `CHK(romv, 4'h6)
    `CHK(selfv, 4'h6)
    bus(OFS_ROMBASE, 1'b1, 32'h0123_4567);
    repeat (2) @(posedge clk);
    `CHK(rom_snap[ROM_W +: ROM_W], 28'habc1234)
    `CHK(rom_snap[2*ROM_W +: ROM_W], 28'h1234567)
    bus(OFS_CONFIG, 1'b1, 32'h0000_0a0c);
    repeat (4) @(posedge clk);
    `CHK(in_rst, 4'h0)
    $display("test warm reset done");
    bus(OFS_EXTREQ, 1'b1, 32'h9);
    `WAITC(lk.debug_acknowledge === 4'h9)
    `CHK(halted, 4'h9)
    bus(OFS_STATUS, 1'b0, 32'h0);
    `CHK(q, 32'h0000_0009)
    bus(OFS_TAKEN, 1'b0, 32'h0);
    `CHK(q, 32'h0000_0009)
    bus(OFS_TAKEN, 1'b1, 32'h1);
    bus(OFS_TAKEN, 1'b0, 32'h0);
    `CHK(q, 32'h0000_0008)
    `CHK(lk.ext_debug_request, 4'h0)
    $display("test external request done");
    bus(OFS_RESTART, 1'b1, 32'h9);
    `WAITC(lk.restart_handshake === 4'h9)
    `CHK(lk.debug_acknowledge, 4'h0)
    `WAITC(lk.restart_handshake === 4'h0)
    `CHK(lk.restart_request, 4'h0)
    `CHK(halted, 4'h0)
    $display("test restart done");
    bus(OFS_HALT, 1'b1, 32'h2);
    `WAITC(lk.debug_acknowledge === 4'h2)
    `CHK(halted, 4'h2)
    bus(OFS_TAKEN, 1'b0, 32'h0);
    `CHK(q, 32'h0000_0008)
    bus(OFS_HALT, 1'b1, 32'h0);
    bus(OFS_RESTART, 1'b1, 32'h2);
    `WAITC(lk.restart_handshake === 4'h2)
    `WAITC(lk.restart_handshake === 4'h0)
    `CHK(halted, 4'h0)
    $display("test halt request done");
    close_out();
  end
endmodule
